// ==== shared/sac_pkg.sv ====
// package for the sar converter control logic: map, fields, codes
`default_nettype none
package sac_pkg;
    // register addresses
    localparam logic [31:0] ADDR_CONTROL = 32'hffff0500;
    localparam logic [31:0] ADDR_POS_SEL = 32'hffff0504;
    localparam logic [31:0] ADDR_NEG_SEL = 32'hffff0508;
    localparam logic [31:0] ADDR_STATUS = 32'hffff050c;
    localparam logic [31:0] ADDR_RESULT = 32'hffff0510;
    localparam logic [31:0] ADDR_IF_RESET = 32'hffff0514;
    // reset values
    localparam logic [15:0] CONTROL_RESET = 16'h0600;
    localparam logic [4:0] POS_SEL_RESET = 5'h00;
    localparam logic [4:0] NEG_SEL_RESET = 5'h01;
    localparam logic [31:0] RESULT_RESET = 32'h00000000;
    // control word field positions
    localparam int CON_EDGE_BIT = 13;
    localparam int CON_CLK_HI = 12;
    localparam int CON_CLK_LO = 10;
    localparam int CON_ACQ_HI = 9;
    localparam int CON_ACQ_LO = 8;
    localparam int CON_START_EN_BIT = 7;
    localparam int CON_BUSY_EN_BIT = 6;
    localparam int CON_POWER_BIT = 5;
    localparam int CON_MODE_HI = 4;
    localparam int CON_MODE_LO = 3;
    localparam int CON_TRIG_HI = 2;
    localparam int CON_TRIG_LO = 0;
    localparam int CON_WIDTH = 16;
    localparam int SEL_WIDTH = 5;
    // result word layout
    localparam int RES_LO = 16;
    localparam int RES_HI = 27;
    // trigger source codes
    localparam logic [2:0] TRIG_EXT_PIN = 3'h0;
    localparam logic [2:0] TRIG_TIMER1 = 3'h1;
    localparam logic [2:0] TRIG_TIMER0 = 3'h2;
    localparam logic [2:0] TRIG_SW_SINGLE = 3'h3;
    localparam logic [2:0] TRIG_SW_CONT = 3'h4;
    localparam logic [2:0] TRIG_LOGIC_ARRAY = 3'h5;
    // input configuration codes
    localparam logic [1:0] MODE_SINGLE_ENDED = 2'h0;
    localparam logic [1:0] MODE_FULL_DIFF = 2'h1;
    localparam logic [1:0] MODE_PSEUDO_DIFF = 2'h2;
    // temperature channel and its forced timing
    localparam logic [4:0] TEMP_CHANNEL = 5'h10;
    localparam logic [1:0] TEMP_ACQ_CODE = 2'h3;
    localparam logic [2:0] TEMP_DIV_CODE = 3'h5;
    // converter clocks for bit trials and result write
    localparam logic [4:0] EXTRA_CLOCKS = 5'h13;
    // sequencer states
    typedef enum logic [2:0] {
        SAC_IDLE = 3'b001,
        SAC_ACQ = 3'b010,
        SAC_CONV = 3'b100
    } sac_state_t;
endpackage
`default_nettype wire

// ==== design/sac_control.sv ====
// sar converter control: registers, trigger, timing and result formatting
//
// How it works
// RQ1 - converter clock is system clock divided by 1,2,4,8,16,32 per field
// RQ2 - acquisition field selects 2, 4, 8 or 16 converter clocks
// RQ3 - nineteen more converter clocks follow acquisition for trials and write
// RQ4 - temperature channel forces 16 acquisition clocks and divide by 32
// RQ5 - after temperature channel, user timing applies again to later channels
// RQ6 - control bit picks edge or level detection of external trigger
// RQ7 - starts accepted only with start enable; clearing it spares continuous runs
// RQ8 - busy pin shows busy only while its enable bit is set
// RQ9 - software powers up and waits 5 us before trusting results
// RQ10 - mode field: single-ended, fully differential, pseudo differential
// RQ11 - twelve-bit result sits in bits 16 to 27 of result word
// RQ12 - top four result word bits copy the result sign
// RQ13 - twos complement when differential, straight binary otherwise
// RQ14 - differential result is shifted one place toward the lsb
// RQ15 - starts from software, external pin, logic array or either timer
// RQ16 - positive and negative inputs chosen by two separate select registers
// RQ17 - temperature sensor is one more selectable input channel
// RQ18 - trigger field picks source; single software returns to 000 when done
// RQ19 - end of conversion sets ready and interrupts; result read clears ready
// RQ20 - busy is high for the whole conversion, low when it ends
// RQ21 - any write to interface reset register restores all register defaults
// RQ22 - continuous mode restarts after each result until trigger field changes
// RQ23 - triggers during a conversion are ignored
`default_nettype none
module sac_control (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [31:0] mmr_addr,
    input wire logic [31:0] mmr_wdata,
    input wire logic mmr_wr,
    input wire logic mmr_rd,
    output logic [31:0] mmr_rdata,
    input wire logic external_start_pin,
    input wire logic timer0_overflow,
    input wire logic timer1_overflow,
    input wire logic logic_array_start,
    input wire logic [11:0] core_result,
    output logic core_clock_strobe,
    output logic core_track,
    output logic core_convert,
    output logic core_power_up,
    output logic [sac_pkg::SEL_WIDTH-1:0] positive_input_select,
    output logic [sac_pkg::SEL_WIDTH-1:0] negative_input_select,
    output logic [1:0] core_mode,
    output logic converter_busy_output,
    output logic result_ready_flag,
    output logic conversion_done_irq
);
    import sac_pkg::*;

    typedef struct packed {
        logic [CON_WIDTH-1:0] con;
        logic [SEL_WIDTH-1:0] cp;
        logic [SEL_WIDTH-1:0] cn;
        logic [31:0] dat;
        logic ready;
        sac_state_t st;
        logic [4:0] divcnt;
        logic [4:0] phase;
        logic [4:0] acq_n;
        logic [2:0] div_code;
        logic [1:0] mode;
        logic [5:0] tick_total;
        logic [31:0] rdata;
        logic ext_sync1;
        logic ext_sync2;
        logic ext_prev;
        logic tick_q;
        logic track_q;
        logic convert_q;
        logic busy_pin;
        logic irq;
    } sac_regs_t;

    localparam sac_regs_t REGS_RESET = '{
        con: CONTROL_RESET, cp: POS_SEL_RESET, cn: NEG_SEL_RESET,
        dat: RESULT_RESET, ready: 1'b0, st: SAC_IDLE, divcnt: 5'h00,
        phase: 5'h00, acq_n: 5'h00, div_code: 3'h0, mode: 2'h0,
        tick_total: 6'h00, rdata: 32'h00000000, ext_sync1: 1'b0,
        ext_sync2: 1'b0, ext_prev: 1'b0, tick_q: 1'b0, track_q: 1'b0,
        convert_q: 1'b0, busy_pin: 1'b0, irq: 1'b0
    };

    sac_regs_t s_q;
    sac_regs_t s_d;
    logic [5:0] divisor;
    logic tick;
    logic ext_hit;
    logic trig_hit;
    logic start;
    logic done;
    logic launch;
    logic temp_sel;
    logic [11:0] field;

    // acquisition length in converter clocks for a 2-bit code
    function automatic logic [4:0] acq_clocks(input logic [1:0] code);
        acq_clocks = 5'h02 << code; // RQ2
    endfunction

    // result field for the latched mode; differential is shifted arithmetically
    function automatic logic [11:0] fmt(input logic [1:0] mode,
                                        input logic [11:0] raw);
        if (mode == MODE_FULL_DIFF) begin
            fmt = {raw[11], raw[11:1]}; // RQ13 RQ14
        end else begin
            fmt = raw; // RQ13
        end
    endfunction

    // next-state logic for the whole block
    always_comb begin
        s_d = s_q;
        // two flops before the pin is looked at
        s_d.ext_sync1 = external_start_pin;
        s_d.ext_sync2 = s_q.ext_sync1;
        s_d.ext_prev = s_q.ext_sync2;
        divisor = 6'h01 << s_q.div_code; // RQ1
        tick = (s_q.st != SAC_IDLE) &&
               (s_q.divcnt == 5'(divisor - 6'h01)); // RQ1
        ext_hit = s_q.con[CON_EDGE_BIT] ?
                  (s_q.ext_sync2 & ~s_q.ext_prev) : s_q.ext_sync2; // RQ6
        // source decode; reserved codes never start anything
        unique case (s_q.con[CON_TRIG_HI:CON_TRIG_LO])
            TRIG_EXT_PIN: trig_hit = ext_hit; // RQ15 RQ18
            TRIG_TIMER1: trig_hit = timer1_overflow; // RQ15 RQ18
            TRIG_TIMER0: trig_hit = timer0_overflow; // RQ15 RQ18
            TRIG_SW_SINGLE: trig_hit = 1'b1; // RQ15 RQ18
            TRIG_SW_CONT: trig_hit = 1'b1; // RQ15 RQ18
            TRIG_LOGIC_ARRAY: trig_hit = logic_array_start; // RQ15 RQ18
            default: trig_hit = 1'b0;
        endcase
        // only an idle converter takes a request
        start = (s_q.st == SAC_IDLE) && s_q.con[CON_START_EN_BIT] &&
                trig_hit; // RQ7 RQ23
        done = (s_q.st == SAC_CONV) && tick &&
               (s_q.phase == EXTRA_CLOCKS - 5'h01); // RQ3
        launch = start;
        temp_sel = (s_q.cp == TEMP_CHANNEL); // RQ17
        field = fmt(s_q.mode, core_result);
        s_d.irq = 1'b0;

        // converter clock divider, held at zero while idle
        if (tick || s_q.st == SAC_IDLE) begin
            s_d.divcnt = 5'h00;
        end else begin
            s_d.divcnt = s_q.divcnt + 5'h01; // RQ1
        end
        if (tick) begin
            s_d.tick_total = s_q.tick_total + 6'h01;
        end

        // sequencer
        unique case (s_q.st)
            SAC_IDLE: begin
                s_d.phase = 5'h00;
            end
            SAC_ACQ: begin
                if (tick) begin
                    if (s_q.phase == s_q.acq_n - 5'h01) begin
                        s_d.st = SAC_CONV; // RQ2
                        s_d.phase = 5'h00;
                    end else begin
                        s_d.phase = s_q.phase + 5'h01;
                    end
                end
            end
            SAC_CONV: begin
                if (tick) begin
                    s_d.phase = s_q.phase + 5'h01; // RQ3
                end
                if (done) begin
                    s_d.st = SAC_IDLE; // RQ20
                    s_d.dat = {{4{field[11]}}, field, 16'h0000}; // RQ11 RQ12
                    s_d.ready = 1'b1; // RQ19
                    s_d.irq = 1'b1; // RQ19
                    if (s_q.con[CON_TRIG_HI:CON_TRIG_LO] == TRIG_SW_SINGLE) begin
                        s_d.con[CON_TRIG_HI:CON_TRIG_LO] = TRIG_EXT_PIN; // RQ18
                    end
                    // continuous runs ignore the start enable
                    if (s_q.con[CON_TRIG_HI:CON_TRIG_LO] == TRIG_SW_CONT) begin
                        launch = 1'b1; // RQ22 RQ7
                    end
                end
            end
        endcase

        // timing is latched per conversion, so temp override ends with it
        if (launch) begin
            s_d.st = SAC_ACQ;
            s_d.phase = 5'h00;
            s_d.divcnt = 5'h00;
            s_d.tick_total = 6'h00;
            s_d.mode = s_q.con[CON_MODE_HI:CON_MODE_LO]; // RQ10
            s_d.acq_n = acq_clocks(temp_sel ? TEMP_ACQ_CODE :
                        s_q.con[CON_ACQ_HI:CON_ACQ_LO]); // RQ4 RQ5
            s_d.div_code = temp_sel ? TEMP_DIV_CODE :
                           s_q.con[CON_CLK_HI:CON_CLK_LO]; // RQ4 RQ5
        end

        // register reads answer one cycle later; unmapped reads give zero
        if (mmr_rd) begin
            unique case (mmr_addr)
                ADDR_CONTROL: s_d.rdata = {16'h0000, s_q.con};
                ADDR_POS_SEL: s_d.rdata = {27'h0000000, s_q.cp};
                ADDR_NEG_SEL: s_d.rdata = {27'h0000000, s_q.cn};
                ADDR_STATUS: s_d.rdata = {31'h00000000, s_q.ready};
                ADDR_RESULT: s_d.rdata = s_q.dat;
                default: s_d.rdata = 32'h00000000;
            endcase
            // a fresh result in the same cycle keeps the flag set
            if (mmr_addr == ADDR_RESULT && !done) begin
                s_d.ready = 1'b0; // RQ19
            end
        end

        // register writes; software beats the single-shot auto clear
        if (mmr_wr) begin
            unique case (mmr_addr)
                ADDR_CONTROL: begin
                    s_d.con = mmr_wdata[CON_WIDTH-1:0];
                    s_d.con[15:14] = 2'h0;
                end
                ADDR_POS_SEL: s_d.cp = mmr_wdata[SEL_WIDTH-1:0]; // RQ16
                ADDR_NEG_SEL: s_d.cn = mmr_wdata[SEL_WIDTH-1:0]; // RQ16
                ADDR_IF_RESET: begin
                    s_d = REGS_RESET; // RQ21
                    s_d.ext_sync1 = external_start_pin;
                    s_d.ext_sync2 = s_q.ext_sync1;
                    s_d.ext_prev = s_q.ext_sync2;
                end
                default: ;
            endcase
        end

        // registered pin and core strobes
        s_d.tick_q = tick;
        s_d.track_q = (s_d.st == SAC_ACQ);
        s_d.convert_q = (s_d.st == SAC_CONV);
        s_d.busy_pin = s_d.con[CON_BUSY_EN_BIT] &&
                       (s_d.st != SAC_IDLE); // RQ8 RQ20
    end

    // single state register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= REGS_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from flops
    assign mmr_rdata = s_q.rdata;
    assign core_clock_strobe = s_q.tick_q;
    assign core_track = s_q.track_q;
    assign core_convert = s_q.convert_q;
    assign core_power_up = s_q.con[CON_POWER_BIT]; // RQ9
    assign positive_input_select = s_q.cp;
    assign negative_input_select = s_q.cn;
    assign core_mode = s_q.mode;
    assign converter_busy_output = s_q.busy_pin;
    assign result_ready_flag = s_q.ready;
    assign conversion_done_irq = s_q.irq;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    a_tick_divisor: assert property ( // RQ1
        (s_q.st != SAC_IDLE) |-> (6'(s_q.divcnt) < divisor))
        else $error("divider count beyond selected divisor");
    a_period_length: assert property ( // RQ3
        done |-> (s_q.tick_total == 6'(s_q.acq_n) + 6'h12))
        else $error("conversion not acquisition plus 19 clocks");
    a_temp_timing: assert property ( // RQ4
        (start && temp_sel) |=> (s_q.acq_n == 5'h10 && s_q.div_code == 3'h5))
        else $error("temperature channel timing not forced");
    a_edge_trigger: assert property ( // RQ6
        (start && s_q.con[CON_EDGE_BIT] && s_q.con[2:0] == TRIG_EXT_PIN)
        |-> (s_q.ext_sync2 && !s_q.ext_prev))
        else $error("edge mode started without an edge");
    a_start_enable: assert property ( // RQ7
        ($rose(s_q.track_q) && $past(s_q.st) == SAC_IDLE)
        |-> $past(s_q.con[CON_START_EN_BIT]))
        else $error("start taken with start enable clear");
    a_busy_gate: assert property ( // RQ8
        !s_q.con[CON_BUSY_EN_BIT] |-> !converter_busy_output)
        else $error("busy pin driven while disabled");
    a_diff_format: assert property ( // RQ14
        (done && s_q.mode == MODE_FULL_DIFF && !mmr_wr)
        |=> (s_q.dat[27:16] == {$past(core_result[11]),
             $past(core_result[11:1])}))
        else $error("differential result not shifted");
    a_sign_fill: assert property ( // RQ12
        s_q.dat[31:28] == {4{s_q.dat[RES_HI]}})
        else $error("upper result bits not sign copies");
    a_ready_set: assert property ( // RQ19
        (done && !mmr_wr) |=> ##[0:1] result_ready_flag)
        else $error("ready not set at end of conversion");
    a_single_clear: assert property ( // RQ18
        (done && s_q.con[2:0] == TRIG_SW_SINGLE && !mmr_wr)
        |=> (s_q.con[2:0] == TRIG_EXT_PIN))
        else $error("single conversion did not return to pin source");

    c_single: cover property (done && s_q.con[2:0] == TRIG_SW_SINGLE);
    c_continuous: cover property (done && s_q.con[2:0] == TRIG_SW_CONT);
    c_temp: cover property (start && temp_sel);
    c_diff: cover property (done && s_q.mode == MODE_FULL_DIFF);
endmodule
`default_nettype wire

// ==== dv/sac_core_model.sv ====
// behavioural analog core: hands back a held sample while converting
`default_nettype none
module sac_core_model (
    input wire logic core_convert,
    input wire logic core_power_up,
    input wire logic [11:0] sample_value,
    output logic [11:0] core_result
);
    timeunit 1ns;
    timeprecision 1ps;
    // outside a powered conversion show the inverse, never stale data
    assign core_result = (core_convert && core_power_up) ? sample_value
                                                         : ~sample_value;
endmodule
`default_nettype wire

// ==== dv/tb_sac_control.sv ====
// self-checking bench for the sar converter control logic
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((e) !== (g)) begin \
    bad_count++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb_sac_control;
    timeunit 1ns;
    timeprecision 1ps;
    import sac_pkg::*;
    logic clk = 0, reset_n = 0, mmr_wr = 0, mmr_rd = 0, rd_seen = 0;
    logic external_start_pin = 0, timer0_overflow = 0, timer1_overflow = 0;
    logic logic_array_start = 0, core_track, core_convert, core_power_up;
    logic [31:0] mmr_addr = 0, mmr_wdata = 0, mmr_rdata, e_v;
    logic [31:0] lfsr_v = 32'h39ca;
    logic [11:0] core_result, sample_value = 12'h000;
    logic [1:0] core_mode;
    logic converter_busy_output, result_ready_flag, conversion_done_irq;
    logic core_clock_strobe;
    logic [4:0] pos_sel, neg_sel;
    logic [31:0] exp_q[$];
    logic [2:0] trig_tab[4] = '{TRIG_EXT_PIN, TRIG_TIMER1, TRIG_TIMER0,
                                TRIG_LOGIC_ARRAY};
    int bad_count = 0, num_checks = 0, n, strobes = 0;

    sac_control u_sac_control (.clk(clk), .reset_n(reset_n),
        .mmr_addr(mmr_addr), .mmr_wdata(mmr_wdata), .mmr_wr(mmr_wr),
        .mmr_rd(mmr_rd), .mmr_rdata(mmr_rdata),
        .external_start_pin(external_start_pin),
        .timer0_overflow(timer0_overflow), .timer1_overflow(timer1_overflow),
        .logic_array_start(logic_array_start), .core_result(core_result),
        .core_clock_strobe(core_clock_strobe), .core_track(core_track),
        .core_convert(core_convert), .core_power_up(core_power_up),
        .positive_input_select(pos_sel), .negative_input_select(neg_sel),
        .core_mode(core_mode), .converter_busy_output(converter_busy_output),
        .result_ready_flag(result_ready_flag),
        .conversion_done_irq(conversion_done_irq));
    sac_core_model u_sac_core_model (.core_convert(core_convert),
        .core_power_up(core_power_up), .sample_value(sample_value),
        .core_result(core_result));

    // 40 mhz system clock
    initial begin
        forever #12.5 clk = ~clk;
    end
    // read answers land one cycle after the strobe edge
    always @(posedge clk) rd_seen <= mmr_rd;
    // converter clock strobes seen by the core, counted off the edge
    always @(negedge clk) begin
        if (core_clock_strobe) strobes <= strobes + 1;
    end
    always @(negedge clk) begin
        if (rd_seen && exp_q.size() > 0) begin
            e_v = exp_q.pop_front();
            `CHK("rdata", e_v, mmr_rdata)
        end
    end

    function automatic logic [31:0] lfsr_next(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [31:0] ctl(logic ed, logic [2:0] dv,
        logic [1:0] aq, logic en, logic bz, logic [1:0] md, logic [2:0] tr);
        return {18'h0, ed, dv, aq, en, bz, 1'b1, md, tr};
    endfunction
    function automatic logic [31:0] word(logic [11:0] f);
        return {{4{f[11]}}, f, 16'h0000};
    endfunction

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic wr(logic [31:0] a, logic [31:0] d);
        mmr_addr = a;
        mmr_wdata = d;
        mmr_wr = 1;
        @(negedge clk);
        mmr_wr = 0;
        // one idle edge so back to back writes never retoggle the strobe
        @(negedge clk);
    endtask
    task automatic rd(logic [31:0] a, logic [31:0] e);
        exp_q.push_back(e);
        mmr_addr = a;
        mmr_rd = 1;
        @(negedge clk);
        mmr_rd = 0;
        @(negedge clk);
    endtask
    // every wait is bounded; running out ends the run as a failure
    task automatic wait_for(ref logic s, output int k);
        k = 0;
        while (s !== 1'b1 && k < 3000) begin
            @(negedge clk);
            k++;
        end
        if (k >= 3000) begin
            bad_count++;
            close_out();
        end
    endtask
    task automatic no_start();
        logic seen;
        seen = 0;
        repeat (60) @(negedge clk) if (core_track) seen = 1;
        `CHK("no start", 1'b0, seen)
    endtask
    task automatic drive(logic [2:0] tr, logic v);
        case (tr)
            TRIG_EXT_PIN: external_start_pin = v;
            TRIG_TIMER1: timer1_overflow = v;
            TRIG_TIMER0: timer0_overflow = v;
            default: logic_array_start = v;
        endcase
    endtask
    // one software conversion: timing window, status, word layout
    task automatic conv(logic [31:0] c, logic [11:0] raw, int t, int d);
        logic [11:0] f;
        int s0;
        sample_value = raw;
        f = (c[4:3] == MODE_FULL_DIFF) ? {raw[11], raw[11:1]} : raw;
        wr(ADDR_CONTROL, c);
        s0 = strobes;
        repeat (3) @(negedge clk);
        `CHK("busy", c[6], converter_busy_output)
        `CHK("mode", c[4:3], core_mode)
        wait_for(result_ready_flag, n);
        `CHK("irq", 1'b1, conversion_done_irq)
        `CHK("duration", t - 3, n)
        `CHK("end busy", 1'b0, converter_busy_output)
        // last strobe trails the last tick by one cycle
        @(negedge clk);
        `CHK("strobes", t / d, strobes - s0)
        rd(ADDR_RESULT, word(f));
        rd(ADDR_STATUS, 32'h0);
        rd(ADDR_CONTROL, c & 32'hfff8);
    endtask

    initial begin
        repeat (10) @(negedge clk);
        reset_n = 1;
        @(negedge clk);
        rd(ADDR_CONTROL, {16'h0, CONTROL_RESET});
        rd(ADDR_POS_SEL, 32'h0);
        rd(ADDR_NEG_SEL, 32'h1);
        rd(ADDR_RESULT, RESULT_RESET);
        rd(32'hffff0520, 32'h0);
        wr(ADDR_CONTROL, 32'h0620);
        repeat (200) @(negedge clk);
        `CHK("power", 1'b1, core_power_up)
        wr(ADDR_CONTROL, 32'hffffffbf);
        no_start();
        rd(ADDR_CONTROL, 32'h3fbf);
        wr(ADDR_CONTROL, ctl(0, 0, 0, 0, 1, 0, TRIG_SW_SINGLE));
        no_start();
        // divider codes 0 to 5 with a spread of acquisition and mode codes
        for (int i = 0; i < 6; i++) begin
            lfsr_v = lfsr_next(lfsr_v);
            conv(ctl(0, i[2:0], i[1:0], 1, !i[0], 2'(i % 3), TRIG_SW_SINGLE),
                 lfsr_v[11:0], ((2 << i[1:0]) + 19) * (1 << i), 1 << i);
        end
        wr(ADDR_POS_SEL, 32'h10);
        rd(ADDR_POS_SEL, 32'h10);
        `CHK("pos pin", 5'h10, pos_sel)
        conv(ctl(0, 0, 0, 1, 1, 0, TRIG_SW_SINGLE), 12'h5a3, 35 * 32, 32);
        wr(ADDR_POS_SEL, 32'h0);
        conv(ctl(0, 0, 0, 1, 1, 0, TRIG_SW_SINGLE), 12'ha5c, 21, 1);
        // each hardware source, held on into its own conversion
        for (int k = 0; k < 4; k++) begin
            wr(ADDR_CONTROL, ctl(0, 0, 0, 1, 1, 0, trig_tab[k]));
            drive(trig_tab[k], 1);
            wait_for(core_track, n);
            repeat (5) @(negedge clk);
            drive(trig_tab[k], 0);
            wait_for(result_ready_flag, n);
            rd(ADDR_RESULT, word(sample_value));
            no_start();
        end
        // edge mode fires once, level mode repeats while the pin is high
        wr(ADDR_CONTROL, ctl(1, 0, 0, 1, 1, 0, TRIG_EXT_PIN));
        external_start_pin = 1;
        wait_for(result_ready_flag, n);
        rd(ADDR_RESULT, word(sample_value));
        no_start();
        wr(ADDR_CONTROL, ctl(0, 0, 0, 1, 1, 0, TRIG_EXT_PIN));
        wait_for(result_ready_flag, n);
        rd(ADDR_RESULT, word(sample_value));
        wait_for(core_track, n);
        external_start_pin = 0;
        repeat (30) @(negedge clk);
        rd(ADDR_RESULT, word(sample_value));
        // continuous runs survive clearing start enable
        wr(ADDR_CONTROL, ctl(0, 0, 0, 1, 1, 0, TRIG_SW_CONT));
        wait_for(result_ready_flag, n);
        rd(ADDR_RESULT, word(sample_value));
        wr(ADDR_CONTROL, ctl(0, 0, 0, 0, 1, 0, TRIG_SW_CONT));
        wait_for(result_ready_flag, n);
        rd(ADDR_RESULT, word(sample_value));
        wr(ADDR_CONTROL, ctl(0, 0, 0, 0, 1, 0, TRIG_EXT_PIN));
        repeat (30) @(negedge clk);
        rd(ADDR_RESULT, word(sample_value));
        no_start();
        // interface reset restores every register
        wr(ADDR_POS_SEL, 32'h5);
        wr(ADDR_NEG_SEL, 32'h3);
        `CHK("neg pin", 5'h03, neg_sel)
        wr(ADDR_IF_RESET, 32'h0);
        @(negedge clk);
        rd(ADDR_CONTROL, {16'h0, CONTROL_RESET});
        rd(ADDR_POS_SEL, 32'h0);
        rd(ADDR_NEG_SEL, 32'h1);
        rd(ADDR_RESULT, RESULT_RESET);
        `CHK("pos pin", 5'h00, pos_sel)
        `CHK("neg pin", 5'h01, neg_sel)
        close_out();
    end
endmodule
`default_nettype wire
